// ---- rtl/ifb_flag_bank.sv ----
// four sticky interrupt flag registers behind a simple register port
// ****************************************
// flag bank top
// ****************************************
// Notes on behaviour
// - flag reads one after request, else zero
// - software reads and writes every flag
// - unused bits read zero, ignore writes
// - all flags zero after reset
// - group two bit 13 parallel port
// - group two bits 12..9 compare 8..5
// - group two bits 8..5 capture 6..3
// - group two bits 1,0 serial two
// - group three bit 14 calendar clock
// - group three bits 6,5 external 4,3
// - group three bits 2,1 two-wire two
// - group four bit 13 charge measure
// - group four bit 8 low voltage
// - group four bit 3 checksum generator
// - group four bits 2,1 uart errors
// - group five bits 13,12 capture/compare 9
// - group five bits 11,10 serial three
// - group five bits 9..7 uart four
// - group five bits 5,4 two-wire three
// - group five bits 3..1 uart three
//
// Our own choices: the register addresses and the address-and-strobe port.
module ifb_flag_bank
  import ifb_pkg::*;
(
  input  logic              sys_clk,                  // system clock
  input  logic              resetn,                   // async reset, low
  input  logic              clk_en,                   // freezes state low
  input  logic [ADDR_W-1:0] reg_addr,                 // register index
  input  logic [DATA_W-1:0] reg_wdata,                // write data
  input  logic              reg_wr,                   // write strobe
  input  logic              reg_rd,                   // read strobe
  output logic [DATA_W-1:0] reg_rdata,                // read data
  input  logic              parallel_port_req,        // event pulse
  input  logic              compare_ch8_req,          // event pulse
  input  logic              compare_ch7_req,          // event pulse
  input  logic              compare_ch6_req,          // event pulse
  input  logic              compare_ch5_req,          // event pulse
  input  logic              capture_ch6_req,          // event pulse
  input  logic              capture_ch5_req,          // event pulse
  input  logic              capture_ch4_req,          // event pulse
  input  logic              capture_ch3_req,          // event pulse
  input  logic              serial_periph2_event_req, // event pulse
  input  logic              serial_periph2_fault_req, // event pulse
  input  logic              calendar_clock_req,       // event pulse
  input  logic              ext_irq4_req,             // event pulse
  input  logic              ext_irq3_req,             // event pulse
  input  logic              twowire2_master_req,      // event pulse
  input  logic              twowire2_slave_req,       // event pulse
  input  logic              charge_measure_req,       // event pulse
  input  logic              low_voltage_req,          // event pulse
  input  logic              checksum_gen_req,         // event pulse
  input  logic              serial_port2_error_req,   // event pulse
  input  logic              serial_port1_error_req,   // event pulse
  input  logic              capture_ch9_req,          // event pulse
  input  logic              compare_ch9_req,          // event pulse
  input  logic              serial_periph3_event_req, // event pulse
  input  logic              serial_periph3_fault_req, // event pulse
  input  logic              serial_port4_tx_req,      // event pulse
  input  logic              serial_port4_rx_req,      // event pulse
  input  logic              serial_port4_error_req,   // event pulse
  input  logic              twowire3_master_req,      // event pulse
  input  logic              twowire3_slave_req,       // event pulse
  input  logic              serial_port3_tx_req,      // event pulse
  input  logic              serial_port3_rx_req,      // event pulse
  input  logic              serial_port3_error_req,   // event pulse
  output logic [DATA_W-1:0] flags_two,                // pending, group 2
  output logic [DATA_W-1:0] flags_three,              // pending, group 3
  output logic [DATA_W-1:0] flags_four,               // pending, group 4
  output logic [DATA_W-1:0] flags_five                // pending, group 5
);

  // ****************************************
  // state and helpers
  // ****************************************

  // all flops of the block
  typedef struct packed {
    logic [DATA_W-1:0] grp2;
    logic [DATA_W-1:0] grp3;
    logic [DATA_W-1:0] grp4;
    logic [DATA_W-1:0] grp5;
    logic [DATA_W-1:0] rdata;
  } ifb_state_t;

  ifb_state_t        st;
  ifb_state_t        next_st;
  logic [DATA_W-1:0] ev2;
  logic [DATA_W-1:0] ev3;
  logic [DATA_W-1:0] ev4;
  logic [DATA_W-1:0] ev5;

  // address decode, shared by write and read paths
  function automatic logic ifb_sel(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    return addr == off;
  endfunction

  // one flag register: write loads, events set on top
  function automatic logic [DATA_W-1:0] ifb_update(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] ev,
    input logic [DATA_W-1:0] mask,
    input logic [DATA_W-1:0] wd,
    input logic              hit
  );
    logic [DATA_W-1:0] base;
    base = hit ? (wd & mask) : cur;
    return (base | ev) & mask;
  endfunction

  // ****************************************
  // event placement
  // ****************************************

  // group two sources
  always_comb
  begin
    ev2 = '0;
    ev2[B2_PARALLEL] = parallel_port_req;
    ev2[B2_CMP8]     = compare_ch8_req;
    ev2[B2_CMP7]     = compare_ch7_req;
    ev2[B2_CMP6]     = compare_ch6_req;
    ev2[B2_CMP5]     = compare_ch5_req;
    ev2[B2_CAP6]     = capture_ch6_req;
    ev2[B2_CAP5]     = capture_ch5_req;
    ev2[B2_CAP4]     = capture_ch4_req;
    ev2[B2_CAP3]     = capture_ch3_req;
    ev2[B2_SER2_EVT] = serial_periph2_event_req;
    ev2[B2_SER2_FLT] = serial_periph2_fault_req;
  end

  // group three sources
  always_comb
  begin
    ev3 = '0;
    ev3[B3_CALENDAR] = calendar_clock_req;
    ev3[B3_EXT4]     = ext_irq4_req;
    ev3[B3_EXT3]     = ext_irq3_req;
    ev3[B3_TW2_MST]  = twowire2_master_req;
    ev3[B3_TW2_SLV]  = twowire2_slave_req;
  end

  // group four sources
  always_comb
  begin
    ev4 = '0;
    ev4[B4_CHARGE]    = charge_measure_req;
    ev4[B4_LOWVOLT]   = low_voltage_req;
    ev4[B4_CHECKSUM]  = checksum_gen_req;
    ev4[B4_UART2_ERR] = serial_port2_error_req;
    ev4[B4_UART1_ERR] = serial_port1_error_req;
  end

  // group five sources
  always_comb
  begin
    ev5 = '0;
    ev5[B5_CAP9]      = capture_ch9_req;
    ev5[B5_CMP9]      = compare_ch9_req;
    ev5[B5_SER3_EVT]  = serial_periph3_event_req;
    ev5[B5_SER3_FLT]  = serial_periph3_fault_req;
    ev5[B5_UART4_TX]  = serial_port4_tx_req;
    ev5[B5_UART4_RX]  = serial_port4_rx_req;
    ev5[B5_UART4_ERR] = serial_port4_error_req;
    ev5[B5_TW3_MST]   = twowire3_master_req;
    ev5[B5_TW3_SLV]   = twowire3_slave_req;
    ev5[B5_UART3_TX]  = serial_port3_tx_req;
    ev5[B5_UART3_RX]  = serial_port3_rx_req;
    ev5[B5_UART3_ERR] = serial_port3_error_req;
  end

  // ****************************************
  // next state
  // ****************************************

  // flag update and read mux
  always_comb
  begin
    next_st      = st;
    next_st.grp2 = ifb_update(st.grp2, ev2, MASK_GRP2, reg_wdata,
                              reg_wr && ifb_sel(reg_addr, OFF_GRP2));
    next_st.grp3 = ifb_update(st.grp3, ev3, MASK_GRP3, reg_wdata,
                              reg_wr && ifb_sel(reg_addr, OFF_GRP3));
    next_st.grp4 = ifb_update(st.grp4, ev4, MASK_GRP4, reg_wdata,
                              reg_wr && ifb_sel(reg_addr, OFF_GRP4));
    next_st.grp5 = ifb_update(st.grp5, ev5, MASK_GRP5, reg_wdata,
                              reg_wr && ifb_sel(reg_addr, OFF_GRP5));
    // data valid only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_rd)
    begin
      if (ifb_sel(reg_addr, OFF_GRP2))
        next_st.rdata = st.grp2;
      else if (ifb_sel(reg_addr, OFF_GRP3))
        next_st.rdata = st.grp3;
      else if (ifb_sel(reg_addr, OFF_GRP4))
        next_st.rdata = st.grp4;
      else if (ifb_sel(reg_addr, OFF_GRP5))
        next_st.rdata = st.grp5;
    end
  end

  // ****************************************
  // registers
  // ****************************************

  // state flops, frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st.grp2  <= RST_FLAGS;
      st.grp3  <= RST_FLAGS;
      st.grp4  <= RST_FLAGS;
      st.grp5  <= RST_FLAGS;
      st.rdata <= RST_FLAGS;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign flags_two   = st.grp2;
  assign flags_three = st.grp3;
  assign flags_four  = st.grp4;
  assign flags_five  = st.grp5;
  assign reg_rdata   = st.rdata;

  // ****************************************
  // checks
  // ****************************************

  // read strobe on a given register
  sequence rd_grp2_s;
    clk_en && reg_rd && reg_addr == OFF_GRP2;
  endsequence

  sequence rd_grp5_s;
    clk_en && reg_rd && reg_addr == OFF_GRP5;
  endsequence

  // write of all zeros to group two
  sequence clr_grp2_s;
    clk_en && reg_wr && reg_addr == OFF_GRP2 && reg_wdata == 16'h0000;
  endsequence

  // write to group three with no events
  sequence wr_grp3_s;
    clk_en && reg_wr && reg_addr == OFF_GRP3 && ev3 == 16'h0000;
  endsequence

  // event on the parallel port source
  sequence pp_event_s;
    clk_en && parallel_port_req;
  endsequence

  // unused bits of a group two read stay zero
  rd_unused_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_grp2_s |=> (reg_rdata & ~MASK_GRP2) == 16'h0000)
    else $error("unused bit read as one");

  // flag registers never hold unused bits
  flag_unused_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (flags_two & ~MASK_GRP2) == 16'h0000 &&
    (flags_five & ~MASK_GRP5) == 16'h0000 &&
    (flags_four & ~MASK_GRP4) == 16'h0000 &&
    (flags_three & ~MASK_GRP3) == 16'h0000)
    else $error("unused flag bit set");

  // event sets its flag next cycle
  event_sets_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    pp_event_s |=> flags_two[B2_PARALLEL])
    else $error("parallel port flag not set");

  // set beats a clearing write
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pp_event_s and clr_grp2_s) |=> flags_two == $past(ev2))
    else $error("clear beat a set");

  // write loads implemented bits
  write_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_grp3_s |=> flags_three == ($past(reg_wdata) & MASK_GRP3))
    else $error("write did not load flags");

  // read returns flags of the strobe cycle
  read_value_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    rd_grp5_s |=> reg_rdata == $past(flags_five))
    else $error("read data wrong");

  // read data only in the cycle after a read
  read_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  // flags sticky without a write
  sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en && flags_four[B4_LOWVOLT] &&
    !(reg_wr && reg_addr == OFF_GRP4) |=> flags_four[B4_LOWVOLT])
    else $error("flag dropped without clear");

  // clock enable low freezes everything
  freeze_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !clk_en |=> $stable(st))
    else $error("state moved while frozen");

  // a cleared flag stays clear for two idle cycles
  clear_holds_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && reg_wr && reg_addr == OFF_GRP3 && !reg_wdata[B3_TW2_MST]
     && !twowire2_master_req)
    ##1 (!twowire2_master_req && !(reg_wr && reg_addr == OFF_GRP3))[*2]
    |-> !flags_three[B3_TW2_MST])
    else $error("two-wire flag set without event");

  // compare channel 8 request lands on its bit
  cmp8_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && compare_ch8_req |=> flags_two[B2_CMP8])
    else $error("compare 8 flag not set");

  // capture channel 3 request lands on its bit
  cap3_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && capture_ch3_req |=> flags_two[B2_CAP3])
    else $error("capture 3 flag not set");

  // serial two fault request lands on its bit
  ser2_fault_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && serial_periph2_fault_req |=> flags_two[B2_SER2_FLT])
    else $error("serial two fault flag not set");

  // calendar clock request lands on its bit
  calendar_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && calendar_clock_req |=> flags_three[B3_CALENDAR])
    else $error("calendar flag not set");

  // external three request lands on its bit
  ext3_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && ext_irq3_req |=> flags_three[B3_EXT3])
    else $error("external three flag not set");

  // charge measure request lands on its bit
  charge_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && charge_measure_req |=> flags_four[B4_CHARGE])
    else $error("charge flag not set");

  // checksum generator request lands on its bit
  checksum_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && checksum_gen_req |=> flags_four[B4_CHECKSUM])
    else $error("checksum flag not set");

  // compare channel 9 request lands on its bit
  cmp9_sets_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && compare_ch9_req |=> flags_five[B5_CMP9])
    else $error("compare 9 flag not set");

  // uart three error request lands on its bit
  uart3_err_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    clk_en && serial_port3_error_req |=> flags_five[B5_UART3_ERR])
    else $error("uart three error flag not set");

endmodule // ifb_flag_bank

// ---- rtl/ifb_pkg.sv ----
// constants for the interrupt flag status bank
package ifb_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ****************************************
  // register offsets, word index
  // ****************************************
  localparam logic [3:0] OFF_GRP2 = 4'h0;
  localparam logic [3:0] OFF_GRP3 = 4'h1;
  localparam logic [3:0] OFF_GRP4 = 4'h2;
  localparam logic [3:0] OFF_GRP5 = 4'h3;

  // ****************************************
  // implemented bits and reset values
  // ****************************************
  localparam logic [15:0] MASK_GRP2 = 16'h3FE3;
  localparam logic [15:0] MASK_GRP3 = 16'h4066;
  localparam logic [15:0] MASK_GRP4 = 16'h210E;
  localparam logic [15:0] MASK_GRP5 = 16'h3FBE;
  localparam logic [15:0] RST_FLAGS = 16'h0000;

  // ****************************************
  // bit positions, group two
  // ****************************************
  localparam int B2_PARALLEL  = 13;
  localparam int B2_CMP8      = 12;
  localparam int B2_CMP7      = 11;
  localparam int B2_CMP6      = 10;
  localparam int B2_CMP5      = 9;
  localparam int B2_CAP6      = 8;
  localparam int B2_CAP5      = 7;
  localparam int B2_CAP4      = 6;
  localparam int B2_CAP3      = 5;
  localparam int B2_SER2_EVT  = 1;
  localparam int B2_SER2_FLT  = 0;

  // ****************************************
  // bit positions, group three
  // ****************************************
  localparam int B3_CALENDAR  = 14;
  localparam int B3_EXT4      = 6;
  localparam int B3_EXT3      = 5;
  localparam int B3_TW2_MST   = 2;
  localparam int B3_TW2_SLV   = 1;

  // ****************************************
  // bit positions, group four
  // ****************************************
  localparam int B4_CHARGE    = 13;
  localparam int B4_LOWVOLT   = 8;
  localparam int B4_CHECKSUM  = 3;
  localparam int B4_UART2_ERR = 2;
  localparam int B4_UART1_ERR = 1;

  // ****************************************
  // bit positions, group five
  // ****************************************
  localparam int B5_CAP9      = 13;
  localparam int B5_CMP9      = 12;
  localparam int B5_SER3_EVT  = 11;
  localparam int B5_SER3_FLT  = 10;
  localparam int B5_UART4_TX  = 9;
  localparam int B5_UART4_RX  = 8;
  localparam int B5_UART4_ERR = 7;
  localparam int B5_TW3_MST   = 5;
  localparam int B5_TW3_SLV   = 4;
  localparam int B5_UART3_TX  = 3;
  localparam int B5_UART3_RX  = 2;
  localparam int B5_UART3_ERR = 1;

endpackage : ifb_pkg

// ---- tb/ifb_periph_src.sv ----
// peripheral event source model driving the flag bank request lines
module ifb_periph_src
(
  input  wire logic        fire,     // raise one request this cycle
  input  wire logic [5:0]  fire_idx, // which source raises it
  output logic      [32:0] req       // one request line per source
);
  timeunit 1ns;
  timeprecision 1ns;

  // one-hot request, high exactly while fire is held
  assign req = fire ? (33'h0_0000_0001 << fire_idx) : 33'h0_0000_0000;

endmodule // ifb_periph_src

// ---- tb/ifb_flag_bank_tb.sv ----
// self-checking bench for the interrupt flag status bank
module ifb_flag_bank_tb
  import ifb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // signals and tables
  // ****************************************
  logic              sys_clk;
  logic              resetn;
  logic              clk_en;
  logic              reg_wr;
  logic              reg_rd;
  logic              fire;
  logic [5:0]        fire_idx;
  logic [32:0]       req;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rd_val;
  logic [DATA_W-1:0] flags [4];
  logic [DATA_W-1:0] grp_mask [4];
  int                fail_count;
  int                checked;
  // flag position of each source, in request line order
  localparam int EV_BIT [33] = '{13, 12, 11, 10, 9, 8, 7, 6, 5, 1, 0,
    14, 6, 5, 2, 1, 13, 8, 3, 2, 1,
    13, 12, 11, 10, 9, 8, 7, 5, 4, 3, 2, 1};
  localparam logic [3:0] GRP_OFF [4] = '{OFF_GRP2, OFF_GRP3, OFF_GRP4,
    OFF_GRP5};

  // ****************************************
  // design and source model
  // ****************************************
  ifb_periph_src i_ifb_periph_src (.fire(fire), .fire_idx(fire_idx),
    .req(req));

  ifb_flag_bank i_ifb_flag_bank (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .parallel_port_req(req[0]), .compare_ch8_req(req[1]),
    .compare_ch7_req(req[2]), .compare_ch6_req(req[3]),
    .compare_ch5_req(req[4]), .capture_ch6_req(req[5]),
    .capture_ch5_req(req[6]), .capture_ch4_req(req[7]),
    .capture_ch3_req(req[8]), .serial_periph2_event_req(req[9]),
    .serial_periph2_fault_req(req[10]), .calendar_clock_req(req[11]),
    .ext_irq4_req(req[12]), .ext_irq3_req(req[13]),
    .twowire2_master_req(req[14]), .twowire2_slave_req(req[15]),
    .charge_measure_req(req[16]), .low_voltage_req(req[17]),
    .checksum_gen_req(req[18]), .serial_port2_error_req(req[19]),
    .serial_port1_error_req(req[20]), .capture_ch9_req(req[21]),
    .compare_ch9_req(req[22]), .serial_periph3_event_req(req[23]),
    .serial_periph3_fault_req(req[24]), .serial_port4_tx_req(req[25]),
    .serial_port4_rx_req(req[26]), .serial_port4_error_req(req[27]),
    .twowire3_master_req(req[28]), .twowire3_slave_req(req[29]),
    .serial_port3_tx_req(req[30]), .serial_port3_rx_req(req[31]),
    .serial_port3_error_req(req[32]),
    .flags_two(flags[0]), .flags_three(flags[1]),
    .flags_four(flags[2]), .flags_five(flags[3]));

  // ****************************************
  // helpers
  // ****************************************
  function automatic int ev_grp(input int i);
    return (i < 11) ? 0 : (i < 16) ? 1 : (i < 21) ? 2 : 3;
  endfunction

  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] want);
    checked++;
    if (seen !== want)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk);
    fire     <= 1'b1;
    fire_idx <= 6'(i);
    @(posedge sys_clk);
    fire <= 1'b0;
    #1;
  endtask

  // clearing write and one event in the same cycle
  task automatic clr_fire(input logic [ADDR_W-1:0] a, input int i);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= 16'h0000;
    fire      <= 1'b1;
    fire_idx  <= 6'(i);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    fire   <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    logic [DATA_W-1:0] want;
    int g;
    resetn = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    fire = 1'b0;
    fire_idx = 6'h00;
    fail_count = 0;
    checked = 0;
    // implemented bits worked out from the source table
    for (int k = 0; k < 4; k++) grp_mask[k] = 16'h0000;
    for (int i = 0; i < 33; i++) grp_mask[ev_grp(i)][EV_BIT[i]] = 1'b1;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values, then unmapped places
    for (int k = 0; k < 4; k++)
    begin
      rd(GRP_OFF[k]);
      check(rd_val, 16'h0000);
    end
    for (int a = 4; a < 16; a++)
    begin
      wr(4'(a), 16'hFFFF);
      rd(4'(a));
      check(rd_val, 16'h0000);
    end
    for (int k = 0; k < 4; k++) check(flags[k], 16'h0000);
    // force and clear every bit of each group
    for (int k = 0; k < 4; k++)
    begin
      wr(GRP_OFF[k], 16'hFFFF);
      rd(GRP_OFF[k]);
      check(rd_val, grp_mask[k]);
      wr(GRP_OFF[k], 16'h0000);
      rd(GRP_OFF[k]);
      check(rd_val, 16'h0000);
    end
    // each source lands on its own bit and stays until cleared
    for (int i = 0; i < 33; i++)
    begin
      g = ev_grp(i);
      want = 16'(1 << EV_BIT[i]);
      pulse(i);
      check(flags[g], want);
      repeat (3) @(posedge sys_clk);
      rd(GRP_OFF[g]);
      check(rd_val, want);
      wr(GRP_OFF[g], 16'h0000);
      rd(GRP_OFF[g]);
      check(rd_val, 16'h0000);
    end
    // clear and event in one cycle: the event bit survives
    wr(OFF_GRP3, 16'hFFFF);
    clr_fire(OFF_GRP3, 12);
    rd(OFF_GRP3);
    check(rd_val, 16'h0040);
    wr(OFF_GRP2, 16'hFFFF);
    clr_fire(OFF_GRP2, 0);
    rd(OFF_GRP2);
    check(rd_val, 16'h2000);
    // strobes and events ignored while the clock enable is low
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(OFF_GRP4, 16'hFFFF);
    pulse(17);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(OFF_GRP4);
    check(rd_val, 16'h0000);
    // reset in mid-run clears at once
    wr(OFF_GRP5, 16'hFFFF);
    @(posedge sys_clk);
    resetn <= 1'b0;
    #1;
    check(flags[3], 16'h0000);
    check(flags[1], 16'h0000);
    check(flags[0], 16'h0000);
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(OFF_GRP5);
    check(rd_val, 16'h0000);
    end_of_test();
  end

endmodule // ifb_flag_bank_tb
